// ==== hw/pulse_counter_pkg.sv ====
// constants, register map and types for one pulse counter unit
// assumes a 20 MHz core clock and a 1.8 GHz instrument data clock for stamps
package pulse_counter_pkg;

  // register byte addresses
  localparam logic [7:0]  CTRL_ADDR      = 8'h00;
  localparam logic [7:0]  PERIOD_ADDR    = 8'h04;
  localparam logic [7:0]  RESULT_ADDR    = 8'h08;
  localparam logic [7:0]  TIME_LO_ADDR   = 8'h0c;
  localparam logic [7:0]  TIME_HI_ADDR   = 8'h10;
  localparam logic [7:0]  STATUS_ADDR    = 8'h14;

  // control and status register fields
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_RISE_BIT   = 3;
  localparam int          CTRL_FALL_BIT   = 4;
  localparam int          CTRL_INTEG_BIT  = 5;
  localparam int          CTRL_OP_LSB     = 6;
  localparam int          CTRL_INPUT_LSB  = 8;
  localparam int          CTRL_GATE_LSB   = 16;
  localparam int          STATUS_OPEN_BIT = 0;
  localparam int          STATUS_GATE_BIT = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0008;

  // timing
  localparam longint      CORE_CLK_HZ     = 64'd20_000_000;
  localparam longint      DATA_CLK_HZ     = 64'd1_800_000_000;
  localparam longint      CLK_PERIOD_PS   = 64'd50_000;
  localparam longint      PERIOD_MIN_PS   = 64'd93_300;
  localparam longint      PERIOD_MAX_PS   = 64'd1_000_000_000_000;
  localparam longint      PERIOD_RESET_PS = 64'd1_000_000_000;
  localparam logic [31:0] PERIOD_MIN_CYCLES =
    32'((PERIOD_MIN_PS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS);
  localparam logic [31:0] PERIOD_MAX_CYCLES_DEFAULT = 32'(PERIOD_MAX_PS / CLK_PERIOD_PS);
  localparam logic [31:0] PERIOD_RESET    = 32'(PERIOD_RESET_PS / CLK_PERIOD_PS);
  localparam logic [63:0] TS_STEP         = 64'(DATA_CLK_HZ / CORE_CLK_HZ);

  // signal sources: trigger inputs, then sequencer triggers, then io bits
  localparam int          NUM_TRIG        = 8;
  localparam int          NUM_SEQ         = 4;
  localparam int          NUM_DIO         = 32;
  localparam int          NUM_GATE        = NUM_TRIG + NUM_SEQ;
  localparam int          NUM_SRC         = NUM_GATE + NUM_DIO;
  localparam int          SEL_W           = 6;
  localparam int          GATE_W          = 4;

  typedef enum logic [1:0] {
    MODE_FREE       = 2'b00,
    MODE_GATED      = 2'b01,
    MODE_GATED_FREE = 2'b10,
    MODE_TAG        = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_ADD  = 2'b01,
    OP_SUB  = 2'b10
  } op_t;

endpackage : pulse_counter_pkg

// ==== hw/pulse_counter_unit.sv ====
// one pulse counter unit: edge counting, four run modes, partner math,
// integration and a plain register port
// assumes pins are asynchronous to core_clk_i; partner result comes from the
// paired unit on the same clock
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module pulse_counter_unit #(
  parameter logic [31:0] PERIOD_MAX_CYCLES = pulse_counter_pkg::PERIOD_MAX_CYCLES_DEFAULT
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  trigger_in_i,
  input  wire logic [3:0]  sequencer_trigger_i,
  input  wire logic [31:0] digital_io_bit_i,
  input  wire logic [31:0] partner_result_i,
  input  wire logic        partner_valid_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [31:0] raw_result_o,
  output logic             raw_valid_o,
  output logic      [31:0] result_o,
  output logic      [63:0] result_time_o,
  output logic             result_valid_o
);

  localparam int NS = pulse_counter_pkg::NUM_SRC;

  // two-stage synchronisers on every source pin
  logic [NS-1:0] src_meta;
  logic [NS-1:0] src_sync;
  logic [NS-1:0] src_pins;

  assign src_pins = {digital_io_bit_i, sequencer_trigger_i, trigger_in_i};

  // configuration and state
  logic [31:0] ctrl;
  logic [31:0] period;
  logic [63:0] time_now;
  logic [31:0] count;
  logic [31:0] timer;
  logic        tag_open;
  logic        in_prev;
  logic        gate_prev;
  logic [31:0] raw_time_lo;
  logic [31:0] raw_time_hi;
  logic [31:0] partner_last;
  logic [31:0] integ_sum;
  logic [31:0] next_ctrl;
  logic [31:0] next_period;
  logic [63:0] next_time_now;
  logic [31:0] next_count;
  logic [31:0] next_timer;
  logic        next_tag_open;
  logic [31:0] next_raw_result;
  logic        next_raw_valid;
  logic [63:0] next_raw_time;
  logic [31:0] next_partner_last;
  logic [31:0] next_integ_sum;
  logic [31:0] next_result;
  logic [63:0] next_result_time;
  logic        next_result_valid;
  logic [31:0] next_rdata;
  logic [63:0] raw_time;

  // decoded controls
  logic                                   enable;
  pulse_counter_pkg::mode_t               mode;
  pulse_counter_pkg::op_t                 op;
  logic                                   sel_rise;
  logic                                   sel_fall;
  logic                                   integrate;
  logic [pulse_counter_pkg::SEL_W-1:0]    in_sel;
  logic [pulse_counter_pkg::GATE_W-1:0]   gate_sel;
  logic [31:0]                            period_eff;
  logic                                   in_now;
  logic                                   gate_now;
  logic                                   ev;
  logic                                   gate_rise;
  logic                                   gate_fall;
  logic                                   period_end;
  logic [31:0]                            count_ev;
  logic                                   cfg_wr;
  logic                                   emit;
  logic [31:0]                            emit_val;
  logic [31:0]                            partner_cur;
  logic [31:0]                            combined;

  assign enable    = ctrl[pulse_counter_pkg::CTRL_ENABLE_BIT];
  assign mode      = pulse_counter_pkg::mode_t'(ctrl[pulse_counter_pkg::CTRL_MODE_LSB +: 2]);
  assign op        = pulse_counter_pkg::op_t'(ctrl[pulse_counter_pkg::CTRL_OP_LSB +: 2]);
  assign sel_rise  = ctrl[pulse_counter_pkg::CTRL_RISE_BIT];
  assign sel_fall  = ctrl[pulse_counter_pkg::CTRL_FALL_BIT];
  assign integrate = ctrl[pulse_counter_pkg::CTRL_INTEG_BIT];
  assign in_sel    = ctrl[pulse_counter_pkg::CTRL_INPUT_LSB +: pulse_counter_pkg::SEL_W];
  assign gate_sel  = ctrl[pulse_counter_pkg::CTRL_GATE_LSB +: pulse_counter_pkg::GATE_W];
  assign cfg_wr    = wr_i && (addr_i == pulse_counter_pkg::CTRL_ADDR ||
                              addr_i == pulse_counter_pkg::PERIOD_ADDR);
  assign raw_time  = {raw_time_hi, raw_time_lo};

  // source and gate selection, unknown codes read as low
  always_comb begin
    in_now   = 1'b0;
    gate_now = 1'b0;
    if (32'(in_sel) < 32'(NS)) begin
      in_now = src_sync[in_sel];
    end
    if (32'(gate_sel) < 32'(pulse_counter_pkg::NUM_GATE)) begin
      gate_now = src_sync[gate_sel];
    end
  end

  // period clamped to the legal span
  always_comb begin
    period_eff = period;
    if (period < pulse_counter_pkg::PERIOD_MIN_CYCLES) begin
      period_eff = pulse_counter_pkg::PERIOD_MIN_CYCLES;
    end else if (period > PERIOD_MAX_CYCLES) begin
      period_eff = PERIOD_MAX_CYCLES;
    end
  end

  assign ev         = (sel_rise && in_now && !in_prev) ||
                      (sel_fall && !in_now && in_prev);
  assign gate_rise  = gate_now && !gate_prev;
  assign gate_fall  = !gate_now && gate_prev;
  assign period_end = timer >= period_eff - 32'd1;
  assign count_ev   = count + {31'd0, ev};

  // counting core: one state update per mode
  always_comb begin
    next_count    = count;
    next_timer    = timer;
    next_tag_open = tag_open;
    emit          = 1'b0;
    emit_val      = 32'd0;
    if (!enable || cfg_wr) begin
      next_count    = 32'd0;
      next_timer    = 32'd0;
      next_tag_open = 1'b0;
    end else begin
      case (mode)
        pulse_counter_pkg::MODE_FREE: begin
          if (period_end) begin
            emit       = 1'b1;
            emit_val   = count_ev;
            next_count = 32'd0;
            next_timer = 32'd0;
          end else begin
            next_count = count_ev;
            next_timer = timer + 32'd1;
          end
        end
        pulse_counter_pkg::MODE_GATED: begin
          if (gate_rise) begin
            next_count = {31'd0, ev};
          end else if (gate_now) begin
            next_count = count_ev;
          end else if (gate_fall) begin
            emit       = 1'b1;
            emit_val   = count;
            next_count = 32'd0;
          end
        end
        pulse_counter_pkg::MODE_GATED_FREE: begin
          if (!gate_now) begin
            next_count = 32'd0;
            next_timer = 32'd0;
          end else if (period_end) begin
            emit       = 1'b1;
            emit_val   = count_ev;
            next_count = 32'd0;
            next_timer = 32'd0;
          end else begin
            next_count = count_ev;
            next_timer = timer + 32'd1;
          end
        end
        pulse_counter_pkg::MODE_TAG: begin
          if (!tag_open) begin
            if (ev) begin
              emit          = 1'b1;
              emit_val      = 32'd1;
              next_tag_open = 1'b1;
              next_timer    = 32'd0;
              next_count    = 32'd0;
            end
          end else if (period_end) begin
            next_timer = 32'd0;
            next_count = 32'd0;
            if (count_ev != 32'd0) begin
              emit     = 1'b1;
              emit_val = count_ev;
            end else begin
              next_tag_open = 1'b0;
            end
          end else begin
            next_count = count_ev;
            next_timer = timer + 32'd1;
          end
        end
        default: begin
          next_count = 32'd0;
          next_timer = 32'd0;
        end
      endcase
    end
  end

  // raw result stage and free-running stamp
  always_comb begin
    next_time_now   = time_now + pulse_counter_pkg::TS_STEP;
    next_raw_valid  = emit;
    next_raw_result = raw_result_o;
    next_raw_time   = raw_time;
    if (emit) begin
      next_raw_result = emit_val;
      next_raw_time   = time_now;
    end
  end

  // partner math and integration
  always_comb begin
    partner_cur       = partner_valid_i ? partner_result_i : partner_last;
    next_partner_last = partner_cur;
    case (op)
      pulse_counter_pkg::OP_ADD: combined = raw_result_o + partner_cur;
      pulse_counter_pkg::OP_SUB: combined = raw_result_o - partner_cur;
      default:                   combined = raw_result_o;
    endcase
    next_integ_sum    = integ_sum;
    next_result       = result_o;
    next_result_time  = result_time_o;
    next_result_valid = raw_valid_o;
    if (!integrate || !enable) begin
      next_integ_sum = 32'd0;
    end
    if (raw_valid_o) begin
      next_result_time = raw_time;
      if (integrate) begin
        next_integ_sum = integ_sum + combined;
        next_result    = integ_sum + combined;
      end else begin
        next_result = combined;
      end
    end
  end

  // register port
  always_comb begin
    next_ctrl   = ctrl;
    next_period = period;
    next_rdata  = 32'd0;
    if (wr_i) begin
      case (addr_i)
        pulse_counter_pkg::CTRL_ADDR:   next_ctrl   = wdata_i;
        pulse_counter_pkg::PERIOD_ADDR: next_period = wdata_i;
        default:                        next_ctrl   = ctrl;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        pulse_counter_pkg::CTRL_ADDR:    next_rdata = ctrl;
        pulse_counter_pkg::PERIOD_ADDR:  next_rdata = period;
        pulse_counter_pkg::RESULT_ADDR:  next_rdata = result_o;
        pulse_counter_pkg::TIME_LO_ADDR: next_rdata = result_time_o[31:0];
        pulse_counter_pkg::TIME_HI_ADDR: next_rdata = result_time_o[63:32];
        pulse_counter_pkg::STATUS_ADDR: begin
          next_rdata[pulse_counter_pkg::STATUS_OPEN_BIT] = tag_open;
          next_rdata[pulse_counter_pkg::STATUS_GATE_BIT] = gate_now;
        end
        default:                         next_rdata = 32'd0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_meta       <= '0;
      src_sync       <= '0;
      in_prev        <= 1'b0;
      gate_prev      <= 1'b0;
      ctrl           <= pulse_counter_pkg::CTRL_RESET;
      period         <= pulse_counter_pkg::PERIOD_RESET;
      time_now       <= 64'd0;
      count          <= 32'd0;
      timer          <= 32'd0;
      tag_open       <= 1'b0;
      raw_result_o   <= 32'd0;
      raw_valid_o    <= 1'b0;
      raw_time_lo    <= 32'd0;
      raw_time_hi    <= 32'd0;
      partner_last   <= 32'd0;
      integ_sum      <= 32'd0;
      result_o       <= 32'd0;
      result_time_o  <= 64'd0;
      result_valid_o <= 1'b0;
      rdata_o        <= 32'd0;
    end else begin
      src_meta       <= src_pins;
      src_sync       <= src_meta;
      in_prev        <= in_now;
      gate_prev      <= gate_now;
      ctrl           <= next_ctrl;
      period         <= next_period;
      time_now       <= next_time_now;
      count          <= next_count;
      timer          <= next_timer;
      tag_open       <= next_tag_open;
      raw_result_o   <= next_raw_result;
      raw_valid_o    <= next_raw_valid;
      raw_time_lo    <= next_raw_time[31:0];
      raw_time_hi    <= next_raw_time[63:32];
      partner_last   <= next_partner_last;
      integ_sum      <= next_integ_sum;
      result_o       <= next_result;
      result_time_o  <= next_result_time;
      result_valid_o <= next_result_valid;
      rdata_o        <= next_rdata;
    end
  end

endmodule : pulse_counter_unit

// ==== tb/pulse_counter_checker.sv ====
// assertions over the ports of one pulse counter unit
// assumes ctrl and period change only through the register port
`timescale 1ns/1ns
module pulse_counter_checker #(
  parameter logic [31:0] PERIOD_MAX_CYCLES = 32'h40
) (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] partner_result_i,
  input wire logic        partner_valid_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic [31:0] raw_result_o,
  input wire logic        raw_valid_o,
  input wire logic [31:0] result_o,
  input wire logic [63:0] result_time_o,
  input wire logic        result_valid_o
);
  logic [31:0] ctrl, per, plast, gap, math, pmin;
  logic [63:0] tlast;
  logic        seen, tseen, wr_ctrl, wr_per;
  assign pmin    = pulse_counter_pkg::PERIOD_MIN_CYCLES;
  assign wr_ctrl = wr_i && addr_i == pulse_counter_pkg::CTRL_ADDR;
  assign wr_per  = wr_i && addr_i == pulse_counter_pkg::PERIOD_ADDR;
  assign math    = ctrl[7:6] == 2'h1 ? raw_result_o + plast :
                   ctrl[7:6] == 2'h2 ? raw_result_o - plast : raw_result_o;
  // seen: a raw result came out since the last config write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl  <= pulse_counter_pkg::CTRL_RESET;
      per   <= 32'h0;
      plast <= 32'h0;
      gap   <= 32'h0;
      tlast <= 64'h0;
      seen  <= 1'b0;
      tseen <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= wdata_i;
      if (wr_per) per <= wdata_i < pmin ? pmin : (wdata_i > PERIOD_MAX_CYCLES ?
                                                   PERIOD_MAX_CYCLES : wdata_i);
      if (partner_valid_i) plast <= partner_result_i;
      if (result_valid_o) tlast <= result_time_o;
      gap   <= raw_valid_o ? 32'h1 : gap + 32'h1;
      seen  <= !(wr_ctrl || wr_per) && (seen || raw_valid_o);
      tseen <= tseen || result_valid_o;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_valid_follows: assert property (raw_valid_o |=> result_valid_o)
    else $error("result strobe missing after raw strobe");
  a_valid_single: assert property (result_valid_o |=> !result_valid_o)
    else $error("result strobe longer than one cycle");
  a_result_holds: assert property (!result_valid_o |-> $stable(result_o))
    else $error("result changed without strobe");
  a_off_silent: assert property (!ctrl[0] && !$past(ctrl[0]) |-> !raw_valid_o)
    else $error("result while unit is off");
  a_stamp_step: assert property (result_valid_o && tseen |->
    result_time_o - tlast == 64'($past(gap)) * pulse_counter_pkg::TS_STEP)
    else $error("stamp step does not match elapsed cycles");
  a_free_period: assert property (raw_valid_o && seen &&
    ctrl[2:1] == pulse_counter_pkg::MODE_FREE |-> gap == per)
    else $error("free running period length wrong");
  a_tag_holdoff: assert property (raw_valid_o && seen &&
    ctrl[2:1] == pulse_counter_pkg::MODE_TAG |-> gap >= per)
    else $error("tag reports closer than hold-off");
  a_op_math: assert property (result_valid_o && $past(seen) && $stable(ctrl) &&
    !ctrl[5] |-> result_o == math)
    else $error("partner operation result wrong");
  a_integ_sum: assert property (result_valid_o && $past(seen) && ctrl[5] &&
    ctrl[7:6] == 2'h0 |-> result_o == $past(result_o) + raw_result_o)
    else $error("integrated sum wrong");
  c_tag: cover property (raw_valid_o && ctrl[2:1] == pulse_counter_pkg::MODE_TAG);
  c_gated: cover property (result_valid_o && ctrl[2:1] == pulse_counter_pkg::MODE_GATED);
  c_integ: cover property (result_valid_o && ctrl[5]);
endmodule : pulse_counter_checker

bind pulse_counter_unit pulse_counter_checker #(
  .PERIOD_MAX_CYCLES(PERIOD_MAX_CYCLES)
) pulse_counter_checker_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .partner_result_i(partner_result_i),
  .partner_valid_i(partner_valid_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .raw_result_o(raw_result_o), .raw_valid_o(raw_valid_o), .result_o(result_o),
  .result_time_o(result_time_o), .result_valid_o(result_valid_o)
);

// ==== tb/pulse_source_model.sv ====
// pulse sources and gate level on the counter's input pins
// assumes commands arrive by nonblocking writes after a clock edge
`timescale 1ns/1ns
module pulse_source_model (
  input  wire logic        core_clk_i,
  input  wire logic        fire_i,
  input  wire logic [7:0]  count_i,
  input  wire logic [5:0]  code_i,
  input  wire logic        gate_i,
  input  wire logic [3:0]  gate_code_i,
  output logic      [7:0]  trigger_o,
  output logic      [3:0]  sequencer_o,
  output logic      [31:0] io_o,
  output logic             busy_o
);
  logic [7:0]  left;
  logic        phase;
  initial begin
    left = 8'h00;
    phase = 1'b0;
  end
  // each pulse one cycle low, then one cycle high
  always @(posedge core_clk_i) begin
    if (fire_i) begin
      left <= count_i;
      phase <= 1'b0;
    end else if (left != 8'h00) begin
      phase <= ~phase;
      if (phase) left <= left - 8'h01;
    end
  end
  assign {io_o, sequencer_o, trigger_o} = (44'(phase && left != 8'h00) << code_i) |
                                          (44'(gate_i) << gate_code_i);
  assign busy_o = left != 8'h00;
endmodule : pulse_source_model

// ==== tb/pulse_counter_unit_test.sv ====
// self-checking bench for one pulse counter unit in all four modes
// assumes the source model drives the pins; the bench plays the paired unit
`timescale 1ns/1ns
module pulse_counter_unit_test;
  localparam logic [31:0] PMAX = 32'h40;
  logic        core_clk_i, rst_n_i, partner_valid_i, wr_i, rd_i, fire, gate, busy, got;
  logic [7:0]  addr_i, n_pulse, trig;
  logic [3:0]  seq, gate_code;
  logic [5:0]  code;
  logic [31:0] digital_io_bit, partner_result_i, wdata_i, rdata_o, raw_result_o, result_o;
  logic [63:0] result_time_o;
  logic        raw_valid_o, result_valid_o;
  logic [5:0]  srcs [6] = '{6'h00, 6'h07, 6'h08, 6'h0b, 6'h0c, 6'h2b};
  logic [31:0] opx [4] = '{32'h2, 32'h66, 32'hffffff9e, 32'h2};
  int          n_errors, n_compared;

  pulse_counter_unit #(.PERIOD_MAX_CYCLES(PMAX)) pulse_counter_unit_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .trigger_in_i(trig),
    .sequencer_trigger_i(seq), .digital_io_bit_i(digital_io_bit), .partner_result_i(partner_result_i),
    .partner_valid_i(partner_valid_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .raw_result_o(raw_result_o), .raw_valid_o(raw_valid_o),
    .result_o(result_o), .result_time_o(result_time_o), .result_valid_o(result_valid_o));
  pulse_source_model pulse_source_model_i (
    .core_clk_i(core_clk_i), .fire_i(fire), .count_i(n_pulse), .code_i(code),
    .gate_i(gate), .gate_code_i(gate_code), .trigger_o(trig), .sequencer_o(seq),
    .io_o(digital_io_bit), .busy_o(busy));

  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd

  task automatic wait_res(input bit need);
    got = 1'b0;
    repeat (80) begin
      @(posedge core_clk_i);
      #1 got = result_valid_o === 1'b1;
      if (got) break;
    end
    if (need && !got) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      stop_test();
    end
  endtask : wait_res

  // settle: wait for the train to end plus the pin synchroniser
  task automatic pulse(input logic [5:0] c, input logic [7:0] n, input bit settle);
    @(posedge core_clk_i);
    code <= c;
    n_pulse <= n;
    fire <= 1'b1;
    @(posedge core_clk_i);
    fire <= 1'b0;
    if (settle) begin
      repeat (40) begin
        @(posedge core_clk_i);
        if (!busy) break;
      end
      if (busy) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, 1'b1, 1'b0);
        stop_test();
      end
      repeat (4) @(posedge core_clk_i);
    end
  endtask : pulse

  task automatic shot(input logic [5:0] c, input logic [7:0] n, input logic [31:0] e);
    pulse(c, n, 1'b0);
    wait_res(1'b1);
    chk(result_o, e);
  endtask : shot

  task automatic cfg(input logic [31:0] c, input logic [31:0] p);
    wr(pulse_counter_pkg::CTRL_ADDR, 32'h0);
    wr(pulse_counter_pkg::PERIOD_ADDR, p);
    wr(pulse_counter_pkg::CTRL_ADDR, c);
  endtask : cfg

  task automatic run(input logic [31:0] c, input logic [5:0] s, input logic [7:0] n,
                     input logic [31:0] e);
    cfg(c, 32'h14);
    wait_res(1'b1);
    shot(s, n, e);
  endtask : run

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] e,
      input logic it, input logic [1:0] op, input logic [5:0] s, input logic [3:0] g);
    return {12'h0, g, 2'h0, s, op, it, e, m, 1'b1};
  endfunction : ctl

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  initial begin
    {rst_n_i, wr_i, rd_i, fire, gate, partner_valid_i} = 6'h00;
    {addr_i, n_pulse, code, gate_code} = 26'h0;
    {wdata_i, partner_result_i} = 64'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(pulse_counter_pkg::CTRL_ADDR, pulse_counter_pkg::CTRL_RESET);
    rd(pulse_counter_pkg::RESULT_ADDR, 32'h0);
    rd(8'h18, 32'h0);
    wr(pulse_counter_pkg::PERIOD_ADDR, 32'h1);
    rd(pulse_counter_pkg::PERIOD_ADDR, 32'h1);
    wr(pulse_counter_pkg::PERIOD_ADDR, 32'hffff);
    rd(pulse_counter_pkg::PERIOD_ADDR, 32'hffff);
    // register keeps the raw value; the timer clamps it to the legal span
    cfg(ctl(2'h0, 2'h1, 1'b0, 2'h0, 6'h10, 4'h0), 32'h1);
    wait_res(1'b1);
    wait_res(1'b1);
    chk(result_o, 32'h0);
    cfg(ctl(2'h0, 2'h1, 1'b0, 2'h0, 6'h10, 4'h0), 32'hffff);
    wait_res(1'b1);
    wait_res(1'b1);
    chk(result_o, 32'h0);
    for (int i = 0; i < 6; i++) begin
      run(ctl(2'h0, 2'(i % 3 + 1), 1'b0, 2'h0, srcs[i], 4'h0), srcs[i], 8'h3,
          i % 3 == 2 ? 32'h6 : 32'h3);
    end
    @(posedge core_clk_i);
    partner_result_i <= 32'h64;
    partner_valid_i <= 1'b1;
    @(posedge core_clk_i);
    partner_valid_i <= 1'b0;
    for (int op = 0; op < 4; op++) begin
      run(ctl(2'h0, 2'h1, 1'b0, 2'(op), 6'h10, 4'h0), 6'h10, 8'h2, opx[op]);
      chk(raw_result_o, 32'h2);
    end
    run(ctl(2'h0, 2'h1, 1'b1, 2'h0, 6'h10, 4'h0), 6'h10, 8'h2, 32'h2);
    shot(6'h10, 8'h2, 32'h4);
    rd(pulse_counter_pkg::RESULT_ADDR, 32'h4);
    rd(pulse_counter_pkg::TIME_LO_ADDR, result_time_o[31:0]);
    rd(pulse_counter_pkg::TIME_HI_ADDR, 32'h0);
    gate_code <= 4'h9;
    cfg(ctl(2'h1, 2'h1, 1'b0, 2'h0, 6'h14, 4'h9), 32'h14);
    pulse(6'h14, 8'h2, 1'b1);
    gate <= 1'b1;
    pulse(6'h14, 8'h4, 1'b1);
    rd(pulse_counter_pkg::STATUS_ADDR, 32'h2);
    gate <= 1'b0;
    wait_res(1'b1);
    chk(result_o, 32'h4);
    cfg(ctl(2'h2, 2'h1, 1'b0, 2'h0, 6'h14, 4'h9), 32'h14);
    gate <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    gate <= 1'b0;
    wait_res(1'b0);
    chk({31'h0, got}, 32'h0);
    gate <= 1'b1;
    shot(6'h14, 8'h3, 32'h3);
    gate <= 1'b0;
    cfg(ctl(2'h3, 2'h1, 1'b0, 2'h0, 6'h14, 4'h0), 32'h14);
    shot(6'h14, 8'h1, 32'h1);
    rd(pulse_counter_pkg::STATUS_ADDR, 32'h1);
    shot(6'h14, 8'h3, 32'h3);
    wr(pulse_counter_pkg::CTRL_ADDR, 32'h8);
    pulse(6'h14, 8'h3, 1'b1);
    wait_res(1'b0);
    chk({31'h0, got}, 32'h0);
    stop_test();
  end
endmodule : pulse_counter_unit_test
